/* File: inc/tlb_diag_pkg.sv */
// constants and types for the tlb diagnostic access block
// assumes a single clock domain and a 32-bit apb register port
package tlb_diag_pkg;

   // apb register offsets (byte addresses)
   localparam logic [7:0] OFF_ADDR  = 8'h00;
   localparam logic [7:0] OFF_CTL   = 8'h04;
   localparam logic [7:0] OFF_WDATA = 8'h08;
   localparam logic [7:0] OFF_RDATA = 8'h0C;

   // values after reset
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic [31:0] CTL_RST  = 32'h0000_0000;
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   localparam logic [7:0]  LRU_RST  = 8'hE4;  // ages 3,2,1,0

   // control register fields
   localparam int CTL_SPACE_BIT  = 0;  // 0 data tlb, 1 io tlb
   localparam int CTL_MMU_EN_BIT = 1;  // mmu enable
   localparam int CTL_CTX_LSB    = 8;  // current context number
   localparam logic [31:0] CTL_MASK = 32'h0000_FF03;

   // diagnostic address fields
   localparam int FMT_SEL_BIT   = 5;   // translation_format_select
   localparam int KIND_LSB      = 2;   // access_kind
   localparam int WR_VALID_BIT  = 3;
   localparam int WR_CTX_LSB    = 4;
   localparam int IO_TYPE_BIT   = 7;
   localparam int IO_SLOT_LSB   = 8;   // explicit_slot_select

   // entry counts
   localparam int PG_ENTRIES = 256;
   localparam int SR_ENTRIES = 4;
   localparam int IO_ENTRIES = 16;

   // entry levels
   localparam logic [1:0] LV_REGION  = 2'b01;
   localparam logic [1:0] LV_SEGMENT = 2'b10;
   localparam logic [1:0] LV_PAGE    = 2'b11;

   // access kinds: bit2 store, bit1 instruction, bit0 supervisor
   typedef enum logic [2:0] {
      KIND_LD_USER_DATA = 3'b000,
      KIND_LD_SUP_DATA  = 3'b001,
      KIND_LD_USER_INST = 3'b010,
      KIND_LD_SUP_INST  = 3'b011,
      KIND_ST_USER_DATA = 3'b100,
      KIND_ST_SUP_DATA  = 3'b101,
      KIND_ST_USER_INST = 3'b110,
      KIND_ST_SUP_INST  = 3'b111
   } access_kind_t;

   // apb access phase state
   typedef enum logic {
      APB_IDLE = 1'b0,
      APB_DONE = 1'b1
   } apb_state_t;

   // page tlb entry
   typedef struct packed {
      logic        valid;
      logic [11:0] tag;   // va[31:20]
      logic [7:0]  ctx;
      logic [21:0] ppn;   // store data [29:8]
      logic        c;
      logic        m;
      logic [2:0]  acc;
   } pg_entry_t;

   // permission check of a 3-bit permission field against an access kind
   function automatic logic perm_ok(input logic [2:0] acc,
                                    input logic [2:0] kind);
      logic sup;
      logic wr;
      logic ex;
      logic ok;
      sup = kind[0];
      wr  = kind[2];
      ex  = kind[1] & ~kind[2];
      ok  = 1'b0;
      if (wr) begin
         ok = (acc == 3'h1) | (acc == 3'h3) |
              (sup & ((acc == 3'h5) | (acc == 3'h7)));
      end else if (ex) begin
         ok = (acc == 3'h2) | (acc == 3'h3) | (acc == 3'h4) |
              (sup & ((acc == 3'h6) | (acc == 3'h7)));
      end else begin
         ok = (acc <= 3'h3) | (acc == 3'h5) |
              (sup & ((acc == 3'h6) | (acc == 3'h7)));
      end
      return ok;
   endfunction

endpackage

/* File: verilog/seg_region_tlb.sv */
// four-entry fully associative segment/region tlb with lru ages
// assumes writes come one at a time from the diagnostic port
`timescale 1ns/1ns
`default_nettype none
module seg_region_tlb
   import tlb_diag_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [31:0] lk_va,
   input  wire logic [7:0]  lk_ctx,
   input  wire logic        lk_sup,
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_va,
   input  wire logic [31:0] wr_data,
   output logic             hit,
   output logic [1:0]       hit_idx,
   output logic [25:0]      hit_ppn,
   output logic             hit_c,
   output logic             hit_m,
   output logic [2:0]       hit_acc,
   output logic [1:0]       hit_lv,
   output logic [7:0]       lru_state
);
   logic        v_q   [SR_ENTRIES];   // valid
   logic [13:0] tag_q [SR_ENTRIES];   // va[31:18]
   logic [7:0]  ctx_q [SR_ENTRIES];   // context number
   logic [25:0] ppn_q [SR_ENTRIES];   // store data [29:4]
   logic [6:0]  att_q [SR_ENTRIES];   // c, m, acc, level
   logic        v_d   [SR_ENTRIES];
   logic [13:0] tag_d [SR_ENTRIES];
   logic [7:0]  ctx_d [SR_ENTRIES];
   logic [25:0] ppn_d [SR_ENTRIES];
   logic [6:0]  att_d [SR_ENTRIES];
   logic [7:0]  age_q;                 // 2-bit age per entry
   logic [7:0]  age_d;
   logic [1:0]  victim;                // entry of age 3
   logic [SR_ENTRIES-1:0] match;

   // per-entry match: region on va[31:24], segment on va[31:18]
   genvar g;
   generate
      for (g = 0; g < SR_ENTRIES; g++) begin : g_match
         assign match[g] = v_q[g] &
            ((att_q[g][1:0] == LV_SEGMENT) ? (tag_q[g] == lk_va[31:18])
                                           : (tag_q[g][13:6] ==
                                              lk_va[31:24])) &
            ((ctx_q[g] == lk_ctx) | lk_sup);
      end
   endgenerate

   // hit priority, lowest entry first
   always_comb begin
      hit     = 1'b0;
      hit_idx = 2'd0;
      for (int i = SR_ENTRIES - 1; i >= 0; i--) begin
         if (match[i]) begin
            hit     = 1'b1;
            hit_idx = 2'(i);
         end
      end
   end

   assign hit_ppn   = ppn_q[hit_idx];
   assign hit_c     = att_q[hit_idx][6];
   assign hit_m     = att_q[hit_idx][5];
   assign hit_acc   = att_q[hit_idx][4:2];
   assign hit_lv    = att_q[hit_idx][1:0];
   assign lru_state = age_q;

   // next entries and ages; ages only change on a write
   always_comb begin
      victim = 2'd0;
      for (int i = 0; i < SR_ENTRIES; i++) begin
         if (age_q[2*i +: 2] == 2'd3) begin
            victim = 2'(i);
         end
      end
      age_d = age_q;
      for (int i = 0; i < SR_ENTRIES; i++) begin
         v_d[i]   = v_q[i];
         tag_d[i] = tag_q[i];
         ctx_d[i] = ctx_q[i];
         ppn_d[i] = ppn_q[i];
         att_d[i] = att_q[i];
      end
      if (wr_en) begin
         // [RULE16] fill least recently used
         v_d[victim]   = wr_va[WR_VALID_BIT];
         tag_d[victim] = wr_va[31:18];
         ctx_d[victim] = wr_va[WR_CTX_LSB +: 8];
         // [RULE18] frame from data[29:4]
         ppn_d[victim] = wr_data[29:4];
         att_d[victim] = {wr_data[7:6], wr_data[4:2], wr_data[1:0]};
         // [RULE14] ages move on writes only
         for (int i = 0; i < SR_ENTRIES; i++) begin
            if (age_q[2*i +: 2] < 2'd3) begin
               age_d[2*i +: 2] = age_q[2*i +: 2] + 2'd1;
            end
         end
         age_d[2*victim +: 2] = 2'd0;
      end
   end

   // register entries and ages
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         age_q <= LRU_RST;
         for (int i = 0; i < SR_ENTRIES; i++) begin
            v_q[i]   <= 1'b0;
            tag_q[i] <= '0;
            ctx_q[i] <= '0;
            ppn_q[i] <= '0;
            att_q[i] <= '0;
         end
      end else begin
         age_q <= age_d;
         for (int i = 0; i < SR_ENTRIES; i++) begin
            v_q[i]   <= v_d[i];
            tag_q[i] <= tag_d[i];
            ctx_q[i] <= ctx_d[i];
            ppn_q[i] <= ppn_d[i];
            att_q[i] <= att_d[i];
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/io_tlb.sv */
// sixteen-entry fully associative io tlb with random replacement
// assumes one diagnostic access at a time
`timescale 1ns/1ns
`default_nettype none
module io_tlb
   import tlb_diag_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [31:0] va,
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   output logic [31:0]      rd_word
);
   logic [19:0] cam_q [IO_ENTRIES];   // va[31:12]
   logic [31:0] ram_q [IO_ENTRIES];   // translation word
   logic [19:0] cam_d [IO_ENTRIES];
   logic [31:0] ram_d [IO_ENTRIES];
   logic [3:0]  rnd_q;                // random replacement counter
   logic [3:0]  rnd_d;
   logic [3:0]  slot;                 // accessed_slot_number
   logic        hit;
   logic        by_match;

   assign by_match = va[IO_TYPE_BIT];

   // [RULE21] slot by match or explicit
   always_comb begin
      hit  = 1'b0;
      slot = va[IO_SLOT_LSB +: 4];
      if (by_match) begin
         slot = 4'h0;
         for (int i = IO_ENTRIES - 1; i >= 0; i--) begin
            if (ram_q[i][10] && (cam_q[i] == va[31:12])) begin
               hit  = 1'b1;
               slot = 4'(i);
            end
         end
      end
   end

   // [RULE22] hit flag and slot number
   assign rd_word = {by_match & hit, ram_q[slot][30:10], 2'b00,
                     slot, 4'h0};

   // write and counter next values
   always_comb begin
      // [RULE20] free-running replacement counter
      rnd_d = rnd_q + 4'h1;
      for (int i = 0; i < IO_ENTRIES; i++) begin
         cam_d[i] = cam_q[i];
         ram_d[i] = ram_q[i];
      end
      if (wr_en) begin
         // [RULE23] explicit slot or random slot
         if (by_match) begin
            cam_d[rnd_q] = va[31:12];
            ram_d[rnd_q] = wr_data;
         end else begin
            cam_d[va[IO_SLOT_LSB +: 4]] = va[31:12];
            ram_d[va[IO_SLOT_LSB +: 4]] = wr_data;
         end
      end
   end

   // register entries and counter
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rnd_q <= 4'h0;
         for (int i = 0; i < IO_ENTRIES; i++) begin
            cam_q[i] <= '0;
            ram_q[i] <= '0;
         end
      end else begin
         rnd_q <= rnd_d;
         for (int i = 0; i < IO_ENTRIES; i++) begin
            cam_q[i] <= cam_d[i];
            ram_q[i] <= ram_d[i];
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/tlb_diagnostic_access.sv */
// diagnostic read and write access to the data tlb and the io tlb
// assumes an apb master on clk, synchronous active-low reset
//
// Overview of operation
// [RULE1] three-bit access kind encodes eight operations
// [RULE2] address bit 5 selects read format
// [RULE3] translation page number from segment or page
// [RULE4] cacheable from valid segment or page entry; code ORs in the indexed page c bit whether or not that entry is valid
// [RULE5] modified from segment hit else page
// [RULE6] permission field from segment hit else page
// [RULE7] translation level: segment level or eleven
// [RULE8] match format returns matched segment entry number
// [RULE9] access allowed needs four conditions
// [RULE10] valid from segment hit or page valid
// [RULE11] match level 01, 10 or 11
// [RULE12] permission ok from segment or page
// [RULE13] address match on context or supervisor
// [RULE14] replacement state in top byte, writes only
// [RULE15] requester lays out write address fields
// [RULE16] segment write to lru, page by index
// [RULE17] address valid bit sets entry valid
// [RULE18] frame from data bits, top two zero
// [RULE19] write level steers entry to its tlb
// [RULE20] io tlb sixteen entries, random replacement
// [RULE21] io address: page, slot, type bit
// [RULE22] io read: hit flag, slot number
// [RULE23] io write: lookup and translation parts
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tlb_diagnostic_access
   import tlb_diag_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr
);
   // apb and register state
   apb_state_t  state_q;       // access phase state
   apb_state_t  state_d;
   logic [31:0] addr_q;        // diagnostic virtual address
   logic [31:0] addr_d;
   logic [31:0] ctl_q;         // space, mmu enable, context
   logic [31:0] ctl_d;
   logic [31:0] rdata_q;       // registered read data
   logic [31:0] rdata_d;
   logic        err_q;         // registered slave error
   logic        err_d;

   // page tlb storage
   pg_entry_t   pg_q [PG_ENTRIES];
   pg_entry_t   pg_d [PG_ENTRIES];

   // decoded fields
   logic        sel_io;        // io tlb selected
   logic        mmu_en;        // mmu enable
   logic [7:0]  cur_ctx;       // current context number
   logic [2:0]  access_kind;   // operation kind
   logic        is_sup;        // supervisor access
   logic        is_store;      // store access
   logic        fmt_xlat;      // translation format selected
   logic [7:0]  pg_idx;        // page index va[19:12]
   pg_entry_t   pe;            // indexed page entry
   logic        pg_hit;        // valid page match

   // segment/region tlb outputs
   logic        sr_hit;
   logic [1:0]  sr_idx;
   logic [25:0] sr_ppn;
   logic        sr_c;
   logic        sr_m;
   logic [2:0]  sr_acc;
   logic [1:0]  sr_lv;
   logic [7:0]  sr_lru;

   // diagnostic results
   logic [31:0] io_word;       // io tlb read word
   logic [31:0] xlat_word;     // translation format
   logic [31:0] match_word;    // match format
   logic        xfer_wr;       // write takes effect this edge
   logic        dtlb_wr;       // data tlb write strobe
   logic        sr_wr;         // segment/region write strobe
   logic        io_wr;         // io tlb write strobe
   logic        acc_flag;      // access_allowed_flag
   logic        pok_flag;      // permission_ok_flag
   logic        vam_flag;      // address_match_flag
   logic [1:0]  entry_level;   // reported level
   logic [2:0]  permission_field;
   logic        sel_m;         // modified bit of chosen entry
   logic        sel_valid_hit; // valid entry found

   // register address check, used for reads and writes
   function automatic logic mapped(input logic [7:0] a);
      logic m;
      m = 1'b0;
      if (a == OFF_ADDR) begin
         m = 1'b1;
      end else if (a == OFF_CTL) begin
         m = 1'b1;
      end else if (a == OFF_WDATA) begin
         m = 1'b1;
      end else if (a == OFF_RDATA) begin
         m = 1'b1;
      end
      return m;
   endfunction

   // control fields
   assign sel_io  = ctl_q[CTL_SPACE_BIT];
   assign mmu_en  = ctl_q[CTL_MMU_EN_BIT];
   assign cur_ctx = ctl_q[CTL_CTX_LSB +: 8];

   // [RULE1] decode access kind bits
   assign access_kind = addr_q[KIND_LSB +: 3];
   assign is_sup      = access_kind[0];
   assign is_store    = access_kind[2];
   // [RULE2] format select bit
   assign fmt_xlat    = addr_q[FMT_SEL_BIT];

   // indexed page entry and its match
   assign pg_idx = addr_q[19:12];
   assign pe     = pg_q[pg_idx];
   assign pg_hit = pe.valid & (pe.tag == addr_q[31:20]) &
                   ((pe.ctx == cur_ctx) | is_sup);

   // segment/region tlb
   seg_region_tlb u_sr (
      .clk       (clk),
      .rst_n     (rst_n),
      .lk_va     (addr_q),
      .lk_ctx    (cur_ctx),
      .lk_sup    (is_sup),
      .wr_en     (sr_wr),
      .wr_va     (addr_q),
      .wr_data   (pwdata),
      .hit       (sr_hit),
      .hit_idx   (sr_idx),
      .hit_ppn   (sr_ppn),
      .hit_c     (sr_c),
      .hit_m     (sr_m),
      .hit_acc   (sr_acc),
      .hit_lv    (sr_lv),
      .lru_state (sr_lru)
   );

   // io tlb
   io_tlb u_io (
      .clk     (clk),
      .rst_n   (rst_n),
      .va      (addr_q),
      .wr_en   (io_wr),
      .wr_data (pwdata),
      .rd_word (io_word)
   );

   // read result fields
   always_comb begin
      // [RULE6] segment hit wins, else indexed page
      permission_field = sr_hit ? sr_acc : pe.acc;
      // [RULE5] modified from segment hit or page
      sel_m = sr_hit ? sr_m : pe.m;
      sel_valid_hit = sr_hit | pg_hit;
      // [RULE13] match with context or supervisor
      vam_flag = sr_hit | pg_hit;
      // [RULE12] segment permission or page permission
      pok_flag = (sr_hit & perm_ok(sr_acc, access_kind)) |
                 perm_ok(pe.acc, access_kind);
      // [RULE9] valid, context, permission, modified
      acc_flag = sel_valid_hit &
                 perm_ok(permission_field, access_kind) &
                 (sel_m | (~is_store & mmu_en));
      // [RULE7] translation level
      entry_level = sr_hit ? sr_lv : LV_PAGE;
      // [RULE3] page number with zeroed bits
      if (sr_hit) begin
         xlat_word[31:8] = {2'b00, sr_ppn[25:10], 6'h00};
      end else begin
         xlat_word[31:8] = {2'b00, pe.ppn};
      end
      // [RULE4] cacheable from segment hit or page
      xlat_word[7]   = (sr_hit & sr_c) | pe.c;
      xlat_word[6]   = sel_m;
      xlat_word[5]   = 1'b0;
      xlat_word[4:2] = permission_field;
      xlat_word[1:0] = entry_level;
      // [RULE14] replacement state in top byte
      match_word[31:24] = sr_lru;
      match_word[23:14] = 10'h000;
      // [RULE8] matched entry number
      match_word[13:12] = sr_hit ? sr_idx : 2'b00;
      match_word[11]    = 1'b0;
      match_word[10]    = acc_flag;
      match_word[9]     = 1'b0;
      // [RULE10] segment hit or page valid
      match_word[8]     = sr_hit | pe.valid;
      match_word[7]     = (sr_hit & sr_c) | pe.c;
      // [RULE11] match level
      if (sr_hit) begin
         match_word[6:5] = (sr_lv == LV_SEGMENT) ? LV_SEGMENT
                                                 : LV_REGION;
      end else begin
         match_word[6:5] = LV_PAGE;
      end
      match_word[4:2] = permission_field;
      match_word[1]   = pok_flag;
      match_word[0]   = vam_flag;
   end

   // write strobes: effect at the edge where pready is high
   assign xfer_wr = psel & penable & pwrite & (state_q == APB_DONE) &
                    (paddr == OFF_WDATA);
   // [RULE19] level field steers the write
   assign dtlb_wr = xfer_wr & ~sel_io & (pwdata[1:0] == LV_PAGE);
   assign sr_wr   = xfer_wr & ~sel_io & (pwdata[1:0] != LV_PAGE);
   assign io_wr   = xfer_wr & sel_io;

   // page tlb next values
   always_comb begin
      for (int i = 0; i < PG_ENTRIES; i++) begin
         pg_d[i] = pg_q[i];
      end
      if (dtlb_wr) begin
         // [RULE16] page write indexed by va[19:12]
         pg_d[pg_idx].tag = addr_q[31:20];
         pg_d[pg_idx].ctx = addr_q[WR_CTX_LSB +: 8];
         // [RULE17] valid from address bit
         pg_d[pg_idx].valid = addr_q[WR_VALID_BIT];
         // [RULE18] frame from data[29:8]
         pg_d[pg_idx].ppn = pwdata[29:8];
         pg_d[pg_idx].c   = pwdata[7];
         pg_d[pg_idx].m   = pwdata[6];
         pg_d[pg_idx].acc = pwdata[4:2];
      end
   end

   // register page tlb
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < PG_ENTRIES; i++) begin
            pg_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < PG_ENTRIES; i++) begin
            pg_q[i] <= pg_d[i];
         end
      end
   end

   // apb slave next values
   always_comb begin
      state_d = state_q;
      addr_d  = addr_q;
      ctl_d   = ctl_q;
      rdata_d = rdata_q;
      err_d   = err_q;
      case (state_q)
         APB_IDLE: begin
            // first access cycle: prepare answer
            if (psel && penable) begin
               state_d = APB_DONE;
               err_d   = ~mapped(paddr);
               rdata_d = DATA_RST;
               if (!pwrite) begin
                  if (paddr == OFF_ADDR) begin
                     rdata_d = addr_q;
                  end else if (paddr == OFF_CTL) begin
                     rdata_d = ctl_q;
                  end else if (paddr == OFF_RDATA) begin
                     if (sel_io) begin
                        rdata_d = io_word;
                     end else if (fmt_xlat) begin
                        rdata_d = xlat_word;
                     end else begin
                        rdata_d = match_word;
                     end
                  end
               end
            end
         end
         APB_DONE: begin
            // completing edge: writes land here
            state_d = APB_IDLE;
            if (psel && penable && pwrite) begin
               if (paddr == OFF_ADDR) begin
                  addr_d = pwdata;
               end else if (paddr == OFF_CTL) begin
                  ctl_d = pwdata & CTL_MASK;
               end
            end
         end
         default: begin
            state_d = APB_IDLE;
         end
      endcase
   end

   // register apb slave state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= APB_IDLE;
         addr_q  <= ADDR_RST;
         ctl_q   <= CTL_RST;
         rdata_q <= DATA_RST;
         err_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         addr_q  <= addr_d;
         ctl_q   <= ctl_d;
         rdata_q <= rdata_d;
         err_q   <= err_d;
      end
   end

   // handshake outputs
   assign pready  = (state_q == APB_DONE);
   assign prdata  = rdata_q;
   assign pslverr = err_q & (state_q == APB_DONE);
endmodule
`default_nettype wire

/* File: verif/tlb_diag_monitor.sv */
// checker for the tlb diagnostic apb port
// assumes binding onto the top module ports
`timescale 1ns/1ns
`default_nettype none
module tlb_diag_monitor
   import tlb_diag_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr
);
   logic [31:0] addr_q, addr_d;  // shadow address
   logic [31:0] ctl_q, ctl_d;    // shadow control
   logic        done;            // access completes
   logic        rd;              // result read completes
   logic        trans;           // translation format read
   logic        match;           // match format read
   assign done  = psel & penable & pready;
   assign rd    = done & !pwrite & (paddr == OFF_RDATA);
   assign trans = rd & !ctl_q[CTL_SPACE_BIT] & addr_q[FMT_SEL_BIT];
   assign match = rd & !ctl_q[CTL_SPACE_BIT] & !addr_q[FMT_SEL_BIT];
   // shadow completed writes
   always_comb begin
      addr_d = addr_q;
      ctl_d  = ctl_q;
      if (done && pwrite && paddr == OFF_ADDR) addr_d = pwdata;
      if (done && pwrite && paddr == OFF_CTL) ctl_d = pwdata;
   end
   // shadow registers
   always_ff @(posedge clk) begin
      addr_q <= rst_n ? addr_d : ADDR_RST;
      ctl_q  <= rst_n ? ctl_d : CTL_RST;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   property p_wait;
      s_setup |-> !pready ##1 pready ##1 !pready;
   endproperty
   property p_err;
      done |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C});
   endproperty
   property p_top;
      trans |-> prdata[31:30] == 2'b00;
   endproperty
   property p_seg;
      trans && prdata[1:0] != LV_PAGE |-> prdata[13:8] == 6'h00;
   endproperty
   property p_io;
      rd && ctl_q[0] && !addr_q[7]
         |-> !prdata[31] && prdata[7:4] == addr_q[11:8];
   endproperty
   property p_lv;
      match |-> prdata[6:5] != 2'b00;
   endproperty
   property p_en;
      match && prdata[6:5] == LV_PAGE |-> prdata[13:12] == 2'b00;
   endproperty
   property p_aok;
      match && prdata[10] |-> prdata[8] && prdata[1] && prdata[0];
   endproperty
   a_wait: assert property (p_wait) else $error("ready timing off");
   a_err: assert property (p_err) else $error("error flag off");
   a_top: assert property (p_top) else $error("page top bits set");
   a_seg: assert property (p_seg) else $error("seg low bits set");
   a_io: assert property (p_io) else $error("io word off");
   a_lv: assert property (p_lv) else $error("match level zero");
   a_en: assert property (p_en) else $error("entry without hit");
   a_aok: assert property (p_aok) else $error("access ok alone");
endmodule
`default_nettype wire

/* File: verif/apb_master_model.sv */
// apb master standing in for the integer unit
// assumes one clock; the bench calls its task
`timescale 1ns/1ns
`default_nettype none
module apb_master_model
   import tlb_diag_pkg::*;
(
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   // idle bus at time zero
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   // one setup plus access transfer
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= (a == OFF_WDATA) ? {2'b00, d[29:0]} : d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~pwdata;
   endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// bench: apb sequences against the tlb diagnostic block
// assumes model and checker compile first
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import tlb_diag_pkg::*;
;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   int          n_fail = 0, cmp_count = 0, cyc = 0;
   tlb_diagnostic_access u_tlb_diagnostic_access (.clk, .rst_n, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
   apb_master_model u_apb_master_model (.clk, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr);
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] x);
      cmp_count++;
      if (got !== x) begin
         n_fail++;
         $display("wrong value at %0t: %h, expected %h", $time, got, x);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_apb_master_model.xfer(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a);
      u_apb_master_model.xfer(1'b0, a, 32'h0, r, e);
   endtask
   // load address, read result, masked compare
   task automatic res(input logic [31:0] va, x, m = '1);
      wr(OFF_ADDR, va);
      rd(OFF_RDATA);
      check(r & m, x);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      if (++cyc == 4000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial begin
      rst_n = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFF_ADDR);
      check(r, ADDR_RST);
      rd(8'h10);
      check(32'(e), 1);
      wr(OFF_CTL, 32'hFFFF_FFFE);
      rd(OFF_CTL);
      check(r, CTL_MASK - 1);
      res(32'h0000_0000, 32'hE400_0062);
      $display("test reset done");
      wr(OFF_CTL, 32'h0000_5A02);
      wr(OFF_ADDR, 32'h4000_05A8);
      wr(OFF_WDATA, 32'h0123_4086);
      res(32'h4000_0020, 32'h0123_4086);
      res(32'h4000_0000, 32'h3900_35C7);
      for (int k = 0; k < 8; k++) begin
         res(32'h4000_0000 | 32'(k << 2), {21'h0, k < 2, 8'h0,
             (k != 2) && (k != 3), 1'b0}, 32'h402);
      end
      wr(OFF_CTL, 32'h0000_5A00);
      res(32'h4000_0000, 32'h3900_31C7);
      $display("test segment done");
      wr(OFF_ADDR, 32'h1234_55A8);
      wr(OFF_WDATA, 32'h0ABC_DECF);
      res(32'h1234_5020, 32'h0ABC_DECF);
      res(32'h1234_5000, 32'h0000_05EF, 32'h00FF_FFFF);
      wr(OFF_ADDR, 32'h7777_75A0);
      wr(OFF_WDATA, 32'h0000_0003);
      res(32'h7777_7000, 32'h0, 32'h100);
      $display("test page done");
      wr(OFF_CTL, 32'h0000_0001);
      wr(OFF_ADDR, 32'hABCD_E500);
      wr(OFF_WDATA, 32'h1234_5400);
      res(32'hABCD_E500, 32'h1234_5450);
      res(32'hABCD_E080, 32'h9234_5450);
      res(32'h1111_1080, 32'h0, 32'h8000_0000);
      wr(OFF_ADDR, 32'h5555_5080);
      wr(OFF_WDATA, 32'h0000_0400);
      res(32'h5555_5080, 32'h8000_0000, 32'h8000_0000);
      $display("test io done");
      tally_and_finish();
   end
endmodule
bind tlb_diagnostic_access tlb_diag_monitor u_tlb_diag_monitor (.clk,
   .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
   .pslverr);
`default_nettype wire
